// File: dv/idm_decoder_assertions.sv
`default_nettype none
module idm_decoder_assertions
    import idm_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       req,
    input wire logic [1:0] mode,
    input wire logic       bit_op,
    input wire logic [7:0] addr,
    input wire logic       ack,
    input wire logic       sfr_sel,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] stack_pointer,
    input wire logic [7:0] program_status_word,
    input wire logic [1:0] active_bank
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence push_s;
        req && mode == IDM_MODE_PUSH;
    endsequence
    sequence dir_hi_s;
        req && mode == IDM_MODE_DIRECT && !bit_op && addr[7] && addr != 8'h81 && addr != 8'hd0;
    endsequence
    ack_after_req_a: assert property (req |=> ack) else $error("ack missing");
    ack_only_req_a: assert property (!req |=> !ack) else $error("stray ack");
    push_sp_step_a: assert property (push_s |=> stack_pointer == $past(stack_pointer) + 8'h01)
        else $error("push step wrong");
    sp_idle_hold_a: assert property (!req |=> $stable(stack_pointer)) else $error("sp moved");
    bank_from_status_a: assert property (active_bank == program_status_word[4:3])
        else $error("bank mismatch");
    sp_reset_val_a: assert property ($rose(rst_n) |-> stack_pointer == 8'h07) else $error("sp reset");
    direct_to_sfr_a: assert property (dir_hi_s |-> sfr_sel && sfr_addr == addr)
        else $error("direct not routed");
    indirect_no_sfr_a: assert property (req && mode == IDM_MODE_INDIRECT |-> !sfr_sel)
        else $error("indirect hit sfr");
    sfr_bit_byte_a: assert property (req && mode == IDM_MODE_DIRECT && bit_op && addr[7]
        && addr[7:3] != 5'h1a |-> sfr_sel && sfr_addr == {addr[7:3], 3'h0}) else $error("bit byte");
endmodule
bind idm_decoder idm_decoder_assertions idm_decoder_assertions_i (.clk(clk), .rst_n(rst_n), .req(req),
    .mode(mode), .bit_op(bit_op), .addr(addr), .ack(ack), .sfr_sel(sfr_sel), .sfr_addr(sfr_addr),
    .stack_pointer(stack_pointer), .program_status_word(program_status_word), .active_bank(active_bank));
`default_nettype wire

// File: dv/idm_decoder_test.sv
`default_nettype none
module idm_decoder_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, req = 0, wr = 0, bit_op = 0, wbit = 0, rbit, ack, sfr_sel, sfr_wr, sfr_bit_err;
    logic ptr_sel = 0;
    logic [1:0] mode = 0, active_bank;
    logic [7:0] addr = 0, wdata = 0, rdata, sfr_addr, sfr_wdata, sfr_rdata, stack_pointer, program_status_word;
    int errors = 0, compares = 0;
    always #25 clk = ~clk;
    idm_decoder idm_decoder_i (.clk(clk), .rst_n(rst_n), .req(req), .wr(wr), .mode(mode), .bit_op(bit_op),
        .addr(addr), .ptr_sel(ptr_sel), .wdata(wdata), .wbit(wbit), .rdata(rdata), .rbit(rbit), .ack(ack),
        .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .sfr_bit_err(sfr_bit_err), .stack_pointer(stack_pointer), .program_status_word(program_status_word),
        .active_bank(active_bank));
    idm_sfr_model idm_sfr_model_i (.clk(clk), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
    task cmp(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one access; checks ack and, if chk, the read result
    task op(input logic [1:0] m, input logic w, input logic b, input logic [7:0] a, input logic [7:0] d,
            input logic [7:0] e, input logic chk);
        mode = m; wr = w; bit_op = b; addr = a; wdata = d; wbit = d[0]; req = 1;
        @(negedge clk);
        cmp({7'h0, ack}, 8'h01);
        if (b) cmp({7'h0, sfr_bit_err}, 8'h00);
        if (chk) cmp(b ? {7'h0, rbit} : rdata, e);
        // idle cycle so req never drops and rises in one time step
        req = 0;
        @(negedge clk);
    endtask
    task tally_and_finish;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #(1000 * 50);
        errors++;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1;
        cmp(stack_pointer, 8'h07);
        op(3, 0, 0, 0, 8'h5a, 0, 0);
        cmp(stack_pointer, 8'h08);
        op(0, 0, 0, 8'h08, 0, 8'h5a, 1);
        op(0, 1, 0, 8'h81, 8'h7e, 0, 0);
        op(0, 0, 0, 8'h81, 0, 8'h7e, 1);
        op(3, 0, 0, 0, 8'ha5, 0, 0);
        op(3, 0, 0, 0, 8'h3c, 0, 0);
        $display("test stack done");
        op(0, 1, 0, 8'hd0, 8'h10, 0, 0);
        cmp(program_status_word, 8'h10);
        cmp({6'h0, active_bank}, 8'h02);
        op(2, 1, 0, 8'h00, 8'h80, 0, 0);
        op(0, 0, 0, 8'h10, 0, 8'h80, 1);
        op(1, 0, 0, 0, 0, 8'h3c, 1);
        op(0, 1, 0, 8'h80, 8'hc3, 0, 0);
        op(0, 0, 0, 8'h80, 0, 8'hc3, 1);
        op(1, 0, 0, 0, 0, 8'h3c, 1);
        op(2, 1, 0, 8'h00, 8'h7f, 0, 0);
        op(1, 0, 0, 0, 0, 8'ha5, 1);
        $display("test routing done");
        op(0, 1, 0, 8'h22, 8'h00, 0, 0);
        op(0, 1, 1, 8'h13, 8'h01, 0, 0);
        op(0, 0, 0, 8'h22, 0, 8'h08, 1);
        op(0, 0, 1, 8'h13, 0, 8'h01, 1);
        op(0, 0, 1, 8'h86, 0, 8'h01, 1);
        op(0, 0, 1, 8'h82, 0, 8'h00, 1);
        op(2, 1, 0, 8'h01, 8'h22, 0, 0);
        op(2, 0, 0, 8'h01, 0, 8'h22, 1);
        ptr_sel = 1;
        op(1, 0, 0, 0, 0, 8'h08, 1);
        ptr_sel = 0;
        $display("test bits done");
        op(0, 1, 0, 8'h81, 8'hff, 0, 0);
        op(3, 0, 0, 0, 8'h77, 0, 0);
        cmp(stack_pointer, 8'h00);
        op(0, 0, 0, 8'h00, 0, 8'h77, 1);
        $display("test wrap done");
        op(0, 1, 1, 8'hd3, 8'h01, 0, 0);
        cmp(program_status_word, 8'h18);
        cmp({6'h0, active_bank}, 8'h03);
        rst_n = 0;
        @(negedge clk);
        rst_n = 1;
        cmp(stack_pointer, 8'h07);
        cmp(program_status_word, 8'h00);
        $display("test status done");
        tally_and_finish;
    end
endmodule
`default_nettype wire

// File: dv/idm_sfr_model.sv
`default_nettype none
module idm_sfr_model (
    input  wire logic       clk,
    input  wire logic       sfr_sel,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] regs [256];
    logic [7:0] last_r;
    always_ff @(posedge clk) if (sfr_sel && sfr_wr) regs[sfr_addr] <= sfr_wdata;
    always_ff @(posedge clk) if (sfr_sel) last_r <= regs[sfr_addr];
    // unselected: show inverse of last value
    assign sfr_rdata = sfr_sel ? regs[sfr_addr] : ~last_r;
endmodule
`default_nettype wire

// File: rtl/idm_decoder.sv
`default_nettype none
module idm_decoder
    import idm_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  req,
    input  wire logic                  wr,
    input  wire logic [1:0]            mode,
    input  wire logic                  bit_op,
    input  wire logic [IDM_AW-1:0]     addr,
    input  wire logic                  ptr_sel,
    input  wire logic [IDM_DW-1:0]     wdata,
    input  wire logic                  wbit,
    output logic      [IDM_DW-1:0]     rdata,
    output logic                       rbit,
    output logic                       ack,
    output logic                       sfr_sel,
    output logic                       sfr_wr,
    output logic      [IDM_AW-1:0]     sfr_addr,
    output logic      [IDM_DW-1:0]     sfr_wdata,
    input  wire logic [IDM_DW-1:0]     sfr_rdata,
    output logic                       sfr_bit_err,
    output logic      [IDM_DW-1:0]     stack_pointer,
    output logic      [IDM_DW-1:0]     program_status_word,
    output logic      [1:0]            active_bank
);
    import idm_pkg::*;

    logic [IDM_DW-1:0]  stack_pointer_r;
    logic [IDM_DW-1:0]  program_status_word_r;
    logic [IDM_DW-1:0]  stack_pointer_nxt;
    logic [IDM_DW-1:0]  program_status_word_nxt;
    logic [IDM_AW-1:0]  byte_addr;
    logic [2:0]         bit_pos;
    logic [IDM_AW-1:0]  ram_addr;
    logic [IDM_AW-1:0]  ptr_addr;
    logic [IDM_DW-1:0]  ram_rdata;
    logic [IDM_DW-1:0]  ptr_rdata;
    logic [IDM_DW-1:0]  cur_byte;
    logic [IDM_DW-1:0]  new_byte;
    logic               ram_we;
    logic               bank_lo;
    logic               bank_hi;
    logic               sp_hit;
    logic               psw_hit;
    logic               bit_ok;
    idm_target_t        tgt;

    assign bank_lo     = program_status_word_r[IDM_PSW_BANK_LO_POS];
    assign bank_hi     = program_status_word_r[IDM_PSW_BANK_HI_POS];
    assign active_bank = {bank_hi, bank_lo};

    // index register of active bank, read on a second port
    assign ptr_addr = IDM_BANK_BASE | {3'h0, active_bank, 2'h0, ptr_sel};

    // byte address and bit position for every mode
    always_comb begin
        byte_addr = addr;
        bit_pos   = 3'h0;
        tgt       = IDM_TGT_LOWER;
        case (mode)
            IDM_MODE_DIRECT: begin
                if (bit_op) begin
                    if (addr <= IDM_BIT_ADDR_TOP) begin
                        byte_addr = IDM_BIT_BYTE_BASE + {4'h0, addr[6:3]};
                    end else begin
                        byte_addr = {addr[7:3], IDM_BITREG_LOW_MASK};
                    end
                    bit_pos = addr[2:0];
                end
                tgt = (byte_addr > IDM_LOWER_TOP) ? IDM_TGT_SFR : IDM_TGT_LOWER;
            end
            IDM_MODE_INDIRECT: begin
                byte_addr = ptr_rdata;
                tgt       = (ptr_rdata > IDM_LOWER_TOP) ? IDM_TGT_UPPER : IDM_TGT_LOWER;
            end
            IDM_MODE_REG: begin
                byte_addr = IDM_BANK_BASE | {3'h0, active_bank, addr[2:0]};
                tgt       = IDM_TGT_LOWER;
            end
            IDM_MODE_PUSH: begin
                byte_addr = stack_pointer_r + 8'h01;
                tgt       = (byte_addr > IDM_LOWER_TOP) ? IDM_TGT_UPPER : IDM_TGT_LOWER;
            end
            default: begin
                byte_addr = addr;
                tgt       = IDM_TGT_LOWER;
            end
        endcase
    end

    // bit access legal on peripheral registers ending in 0 or 8 only
    assign bit_ok  = (byte_addr[2:0] == IDM_BITREG_LOW_MASK);
    assign sp_hit  = (tgt == IDM_TGT_SFR) && (byte_addr == IDM_SP_OFFSET);
    assign psw_hit = (tgt == IDM_TGT_SFR) && (byte_addr == IDM_PSW_OFFSET);
    assign ram_addr = byte_addr;

    idm_ram #(
        .DEPTH (IDM_RAM_BYTES),
        .DW    (IDM_DW)
    ) u_ram (
        .clk   (clk),
        .we    (ram_we),
        .waddr (ram_addr),
        .wdata (new_byte),
        .raddr (ram_addr),
        .rdata (ram_rdata)
    );

    // second read view for the pointer register, a duplicate array given the same writes as u_ram
    idm_ram #(
        .DEPTH (IDM_RAM_BYTES),
        .DW    (IDM_DW)
    ) u_ptr_shadow (
        .clk   (clk),
        .we    (ram_we),
        .waddr (ram_addr),
        .wdata (new_byte),
        .raddr (ptr_addr),
        .rdata (ptr_rdata)
    );

    always_comb begin
        if (sp_hit) begin
            cur_byte = stack_pointer_r;
        end else if (psw_hit) begin
            cur_byte = program_status_word_r;
        end else if (tgt == IDM_TGT_SFR) begin
            cur_byte = sfr_rdata;
        end else begin
            cur_byte = ram_rdata;
        end
    end

    // read-modify-write for bit writes
    always_comb begin
        new_byte = wdata;
        if (bit_op && mode == IDM_MODE_DIRECT) begin
            new_byte          = cur_byte;
            new_byte[bit_pos] = wbit;
        end
    end

    assign ram_we = req && (wr || mode == IDM_MODE_PUSH) && (tgt != IDM_TGT_SFR);

    always_comb begin
        stack_pointer_nxt = stack_pointer_r;
        if (req && mode == IDM_MODE_PUSH) begin
            stack_pointer_nxt = stack_pointer_r + 8'h01;
        end else if (req && wr && sp_hit && !(bit_op && !bit_ok)) begin
            stack_pointer_nxt = new_byte;
        end
    end

    always_comb begin
        program_status_word_nxt = program_status_word_r;
        if (req && wr && psw_hit && mode != IDM_MODE_PUSH) begin
            program_status_word_nxt = new_byte;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_pointer_r <= IDM_SP_RESET;
        end else begin
            stack_pointer_r <= stack_pointer_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            program_status_word_r <= IDM_PSW_RESET;
        end else begin
            program_status_word_r <= program_status_word_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata       <= 8'h00;
            rbit        <= 1'b0;
            ack         <= 1'b0;
            sfr_bit_err <= 1'b0;
        end else begin
            ack         <= req;
            sfr_bit_err <= req && bit_op && (tgt == IDM_TGT_SFR) && !bit_ok;
            if (req) begin
                rdata <= cur_byte;
                rbit  <= cur_byte[bit_pos];
            end
        end
    end

    // other peripheral registers lie outside; unoccupied ones are not trapped
    always_comb begin
        sfr_sel   = req && (tgt == IDM_TGT_SFR) && !sp_hit && !psw_hit;
        sfr_wr    = sfr_sel && wr && !(bit_op && !bit_ok);
        sfr_addr  = byte_addr;
        sfr_wdata = new_byte;
    end

    assign stack_pointer       = stack_pointer_r;
    assign program_status_word = program_status_word_r;
endmodule
`default_nettype wire

// File: rtl/idm_pkg.sv
`default_nettype none
package idm_pkg;
    localparam int          IDM_AW              = 8;
    localparam int          IDM_DW              = 8;
    localparam int          IDM_RAM_BYTES       = 256;
    localparam logic [7:0]  IDM_LOWER_TOP       = 8'h7f;
    localparam logic [7:0]  IDM_BANK_BASE       = 8'h00;
    localparam int          IDM_BANK_REGS       = 8;
    localparam logic [7:0]  IDM_BIT_BYTE_BASE   = 8'h20;
    localparam logic [7:0]  IDM_BIT_ADDR_TOP    = 8'h7f;
    localparam logic [7:0]  IDM_SP_OFFSET       = 8'h81;
    localparam logic [7:0]  IDM_PSW_OFFSET      = 8'hd0;
    localparam logic [7:0]  IDM_SP_RESET        = 8'h07;
    localparam logic [7:0]  IDM_PSW_RESET       = 8'h00;
    localparam int          IDM_PSW_BANK_LO_POS = 3;
    localparam int          IDM_PSW_BANK_HI_POS = 4;
    localparam logic [2:0]  IDM_BITREG_LOW_MASK = 3'h0;
    localparam logic [1:0]  IDM_MODE_DIRECT     = 2'h0;
    localparam logic [1:0]  IDM_MODE_INDIRECT   = 2'h1;
    localparam logic [1:0]  IDM_MODE_REG        = 2'h2;
    localparam logic [1:0]  IDM_MODE_PUSH       = 2'h3;
    typedef enum logic [2:0] {
        IDM_TGT_LOWER = 3'b001,
        IDM_TGT_UPPER = 3'b010,
        IDM_TGT_SFR   = 3'b100
    } idm_target_t;
endpackage
`default_nettype wire

// File: rtl/idm_ram.sv
`default_nettype none
module idm_ram #(
    parameter int DEPTH = 256,
    parameter int DW    = 8
) (
    input  wire logic                     clk,
    input  wire logic                     we,
    input  wire logic [$clog2(DEPTH)-1:0] waddr,
    input  wire logic [DW-1:0]            wdata,
    input  wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic      [DW-1:0]            rdata
);
    logic [DW-1:0] mem [DEPTH];

    // refuse a depth that leaves no address bit
    if (DEPTH < 2) begin : g_depth_bad
        $error("idm_ram depth too small");
    end

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = mem[raddr];
endmodule
`default_nettype wire
